// ===== hdl/pabim_pkg.sv
package pabim_pkg;

   // ***************************************************************
   // Register offsets (byte addresses)
   // ***************************************************************
   localparam logic [11:0] phy_register_access_off = 12'h054;
   localparam logic [11:0] bus_reset_info_off      = 12'h058;
   localparam logic [11:0] maintenance_control_off = 12'h05c;
   localparam logic [11:0] link_event_flags_off    = 12'h060;
   localparam logic [11:0] link_event_enable_off   = 12'h064;
   localparam logic [11:0] bus_ctl_off             = 12'h068;

   // ***************************************************************
   // Field positions
   // ***************************************************************
   localparam int read_req_bit      = 31;
   localparam int write_req_bit     = 30;
   localparam int target_addr_lsb   = 24;
   localparam int write_value_lsb   = 16;
   localparam int reply_addr_lsb    = 8;
   localparam int info_ok_bit       = 31;
   localparam int node_total_lsb    = 24;
   localparam int root_bit          = 23;
   localparam int contender_bit     = 22;
   localparam int rm_id_lsb         = 16;
   localparam int bus_id_lsb        = 6;
   localparam int inj_hdr_bit       = 31;
   localparam int inj_pay_bit       = 30;
   localparam int drop_bit          = 29;
   localparam int force_ack_bit     = 28;
   localparam int no_ack_bit        = 27;
   localparam int ack_value_lsb     = 16;
   localparam int reply_event_bit   = 9;
   localparam int reset_bus_id_bit  = 0;

   // ***************************************************************
   // Reset values and timing
   // ***************************************************************
   localparam logic [5:0] rm_id_reset      = 6'h3f;
   localparam logic [9:0] bus_id_reset     = 10'h3ff;
   localparam logic [5:0] node_id_reset    = 6'h3f;
   localparam int         clk_period_ns    = 20;
   localparam int         ping_tick_ns     = 40;
   localparam int         ping_tick_cycles = (ping_tick_ns + clk_period_ns - 1) / clk_period_ns;

endpackage

// ===== hdl/pabim_top.sv
// Operation
// R1: Read request sends a PHY register read, then self-clears.
// R2: Write request sends address and data to the PHY, then self-clears.
// R3: Latest PHY reply address is captured.
// R4: Latest PHY reply data is captured with its address.
// R5: Reserved bits ignore writes and read zero.
// R6: Bus info valid set once bus results are stored.
// R7: Node count is a 6-bit read-only field.
// R8: Root flag set while local node is root.
// R9: Contender bit follows the live contender pin.
// R10: Resource manager ID, all ones when absent and at reset.
// R11: Bus number forced to all ones on bus reset when control set.
// R12: Node number all ones at reset and on bus reset.
// R13: Header error bit corrupts header CRC of next packet.
// R14: Payload error bit corrupts data CRC of next packet.
// R15: Drop bit discards the next primary packet.
// R16: Force bit sends the programmed acknowledge value next.
// R17: Suppress bit sends no acknowledge.
// R18: Five maintenance one-shots self-clear after next packet sent.
// R19: Ping timer counts in 40 ns ticks, 8 bits.
// R20: PHY reply sets event flag; enabled flag drives link interrupt.
// R21: Both requests set: read goes first, then write.
module pabim_top (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // PHY request port
   output logic             phy_req_valid,
   output logic             phy_req_write,
   output logic      [3:0]  phy_req_addr,
   output logic      [7:0]  phy_req_data,
   input  wire logic        phy_req_ready,
   // PHY register reply
   input  wire logic        phy_reply_valid,
   input  wire logic [3:0]  phy_reply_addr,
   input  wire logic [7:0]  phy_reply_data,
   // Bus reset results from link core
   input  wire logic        bus_reset_seen,
   input  wire logic        self_id_done,
   input  wire logic [5:0]  self_id_node_total,
   input  wire logic [5:0]  self_id_node_id,
   input  wire logic [5:0]  self_id_rm_id,
   input  wire logic        self_id_root,
   input  wire logic        contender_pin,
   // Transmitter hooks
   input  wire logic        tx_packet_done,
   output logic             tx_inject_header_error,
   output logic             tx_inject_payload_error,
   output logic             tx_drop_next_packet,
   output logic             tx_force_ack,
   output logic             tx_suppress_ack,
   output logic      [7:0]  tx_ack_value,
   input  wire logic        ping_start,
   input  wire logic        ping_stop,
   output logic             link_irq
);

   // ***************************************************************
   // Storage
   // ***************************************************************
   logic       read_req_reg, write_req_reg;
   logic [3:0] phy_target_address_reg;
   logic [7:0] phy_write_value_reg;
   logic [3:0] phy_reply_address_reg;
   logic [7:0] phy_reply_value_reg;
   logic       bus_info_ok_reg, root_reg;
   logic [5:0] node_total_reg, resource_manager_id_reg, local_node_id_reg;
   logic [9:0] bus_id_field_reg;
   logic       reset_bus_id_ctl_reg;
   logic [4:0] maint_reg;   // hdr, pay, drop, force, noack
   logic [7:0] ack_value_reg;
   logic [7:0] ping_response_time_reg;
   logic       ping_run_reg;
   logic       ping_tick_reg;
   logic       reply_flag_reg, reply_enable_reg;
   logic       cont_meta_reg, cont_sync_reg;
   logic       req_busy_reg;

   logic wr_en, rd_en, clr_one;
   assign wr_en = psel & penable & pwrite;
   assign rd_en = psel & ~penable & ~pwrite;

   // ***************************************************************
   // APB bus slave
   // ***************************************************************
   // Zero-wait: pready stays high so every access finishes in one access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= 1'b1;
         pslverr <= 1'b0;
      end
   end

   // Read data registered in setup phase, valid through the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (rd_en) begin
         if (paddr == pabim_pkg::phy_register_access_off) begin
            prdata <= {read_req_reg, write_req_reg, 2'b00, phy_target_address_reg,
                       phy_write_value_reg, 4'h0, phy_reply_address_reg,
                       phy_reply_value_reg};                         // see R5
         end else if (paddr == pabim_pkg::bus_reset_info_off) begin
            prdata <= {bus_info_ok_reg, 1'b0, node_total_reg, root_reg,
                       cont_sync_reg, resource_manager_id_reg, bus_id_field_reg,
                       local_node_id_reg};                           // see R7
         end else if (paddr == pabim_pkg::maintenance_control_off) begin
            prdata <= {maint_reg, 3'b000, ack_value_reg, 8'h00,
                       ping_response_time_reg};                      // see R5
         end else if (paddr == pabim_pkg::link_event_flags_off) begin
            prdata <= 32'(reply_flag_reg) << pabim_pkg::reply_event_bit;
         end else if (paddr == pabim_pkg::link_event_enable_off) begin
            prdata <= 32'(reply_enable_reg) << pabim_pkg::reply_event_bit;
         end else if (paddr == pabim_pkg::bus_ctl_off) begin
            prdata <= 32'(reset_bus_id_ctl_reg);
         end else begin
            prdata <= 32'h0000_0000;
         end
      end
   end

   // ***************************************************************
   // PHY register access
   // ***************************************************************
   // Software-owned fields of the access register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phy_target_address_reg <= 4'h0;
         phy_write_value_reg    <= 8'h00;
      end else if (wr_en && paddr == pabim_pkg::phy_register_access_off) begin
         phy_target_address_reg <= pwdata[pabim_pkg::target_addr_lsb +: 4];
         phy_write_value_reg    <= pwdata[pabim_pkg::write_value_lsb +: 8];
      end
   end

   // Request bits: set by software, cleared when the PHY takes the request.
   // A software set in the clear cycle wins so a new request is not lost.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         read_req_reg  <= 1'b0;
         write_req_reg <= 1'b0;
      end else begin
         if (wr_en && paddr == pabim_pkg::phy_register_access_off
             && pwdata[pabim_pkg::read_req_bit]) begin
            read_req_reg <= 1'b1;
         end else if (req_busy_reg && phy_req_ready && !phy_req_write) begin
            read_req_reg <= 1'b0;                                    // see R1
         end
         if (wr_en && paddr == pabim_pkg::phy_register_access_off
             && pwdata[pabim_pkg::write_req_bit]) begin
            write_req_reg <= 1'b1;
         end else if (req_busy_reg && phy_req_ready && phy_req_write) begin
            write_req_reg <= 1'b0;                                   // see R2
         end
      end
   end

   // Request launcher; read wins when both are pending
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         req_busy_reg  <= 1'b0;
         phy_req_valid <= 1'b0;
         phy_req_write <= 1'b0;
         phy_req_addr  <= 4'h0;
         phy_req_data  <= 8'h00;
      end else if (req_busy_reg) begin
         if (phy_req_ready) begin
            req_busy_reg  <= 1'b0;
            phy_req_valid <= 1'b0;
         end
      end else if (read_req_reg) begin
         req_busy_reg  <= 1'b1;                                      // see R21
         phy_req_valid <= 1'b1;
         phy_req_write <= 1'b0;
         phy_req_addr  <= phy_target_address_reg;                    // see R1
      end else if (write_req_reg) begin
         req_busy_reg  <= 1'b1;
         phy_req_valid <= 1'b1;
         phy_req_write <= 1'b1;
         phy_req_addr  <= phy_target_address_reg;                    // see R2
         phy_req_data  <= phy_write_value_reg;
      end
   end

   // Reply capture keeps address and data paired
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phy_reply_address_reg <= 4'h0;
         phy_reply_value_reg   <= 8'h00;
      end else if (phy_reply_valid) begin
         phy_reply_address_reg <= phy_reply_addr;                    // see R3
         phy_reply_value_reg   <= phy_reply_data;                    // see R4
      end
   end

   // Reply event flag, write one to clear; a new reply wins over the clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reply_flag_reg   <= 1'b0;
         reply_enable_reg <= 1'b0;
         link_irq         <= 1'b0;
      end else begin
         if (phy_reply_valid) begin
            reply_flag_reg <= 1'b1;                                  // see R20
         end else if (wr_en && paddr == pabim_pkg::link_event_flags_off
                      && pwdata[pabim_pkg::reply_event_bit]) begin
            reply_flag_reg <= 1'b0;
         end
         if (wr_en && paddr == pabim_pkg::link_event_enable_off) begin
            reply_enable_reg <= pwdata[pabim_pkg::reply_event_bit];
         end
         link_irq <= reply_flag_reg & reply_enable_reg;              // see R20
      end
   end

   // ***************************************************************
   // Bus reset information
   // ***************************************************************
   // Contender pin synchroniser
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cont_meta_reg <= 1'b0;
         cont_sync_reg <= 1'b0;
      end else begin
         cont_meta_reg <= contender_pin;
         cont_sync_reg <= cont_meta_reg;                             // see R9
      end
   end

   // Software control for the bus-number reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reset_bus_id_ctl_reg <= 1'b0;
      end else if (wr_en && paddr == pabim_pkg::bus_ctl_off) begin
         reset_bus_id_ctl_reg <= pwdata[pabim_pkg::reset_bus_id_bit];
      end
   end

   // Bus reset invalidates results until self-ID completes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bus_info_ok_reg         <= 1'b0;
         node_total_reg          <= 6'h00;
         root_reg                <= 1'b0;
         resource_manager_id_reg <= pabim_pkg::rm_id_reset;          // see R10
         bus_id_field_reg        <= pabim_pkg::bus_id_reset;
         local_node_id_reg       <= pabim_pkg::node_id_reset;        // see R12
      end else if (bus_reset_seen) begin
         bus_info_ok_reg         <= 1'b0;
         local_node_id_reg       <= pabim_pkg::node_id_reset;        // see R12
         resource_manager_id_reg <= pabim_pkg::rm_id_reset;          // see R10
         if (reset_bus_id_ctl_reg) begin
            bus_id_field_reg <= pabim_pkg::bus_id_reset;             // see R11
         end
      end else if (self_id_done) begin
         bus_info_ok_reg         <= 1'b1;                            // see R6
         node_total_reg          <= self_id_node_total;              // see R7
         root_reg                <= self_id_root;                    // see R8
         resource_manager_id_reg <= self_id_rm_id;                   // see R10
         local_node_id_reg       <= self_id_node_id;
      end
   end

   // ***************************************************************
   // Maintenance hooks
   // ***************************************************************
   // One-shots clear after the next packet; a software write in that cycle wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         maint_reg     <= 5'b00000;
         ack_value_reg <= 8'h00;
      end else if (wr_en && paddr == pabim_pkg::maintenance_control_off) begin
         maint_reg     <= pwdata[pabim_pkg::no_ack_bit +: 5];
         ack_value_reg <= pwdata[pabim_pkg::ack_value_lsb +: 8];     // see R16
      end else if (tx_packet_done) begin
         maint_reg <= 5'b00000;                                      // see R18
      end
   end

   // Registered hook outputs towards the transmitter
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_inject_header_error  <= 1'b0;
         tx_inject_payload_error <= 1'b0;
         tx_drop_next_packet     <= 1'b0;
         tx_force_ack            <= 1'b0;
         tx_suppress_ack         <= 1'b0;
         tx_ack_value            <= 8'h00;
      end else begin
         tx_inject_header_error  <= maint_reg[4];                    // see R13
         tx_inject_payload_error <= maint_reg[3];                    // see R14
         tx_drop_next_packet     <= maint_reg[2];                    // see R15
         tx_force_ack            <= maint_reg[1];                    // see R16
         tx_suppress_ack         <= maint_reg[0];                    // see R17
         tx_ack_value            <= ack_value_reg;
      end
   end

   // Ping timer in 40 ns ticks, saturating; the tick on the stop edge still counts
   assign clr_one = (pabim_pkg::ping_tick_cycles > 1) ? ping_tick_reg : 1'b1;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ping_run_reg           <= 1'b0;
         ping_tick_reg          <= 1'b0;
         ping_response_time_reg <= 8'h00;
      end else if (ping_start) begin
         ping_run_reg           <= 1'b1;
         ping_tick_reg          <= 1'b0;
         ping_response_time_reg <= 8'h00;
      end else if (ping_run_reg) begin
         ping_tick_reg <= ~ping_tick_reg;
         if (ping_stop) begin
            ping_run_reg <= 1'b0;
         end
         if (clr_one && ping_response_time_reg != 8'hff) begin
            ping_response_time_reg <= ping_response_time_reg + 8'h01; // see R19
         end
      end
   end

endmodule

// ===== verification/pabim_checker.sv
// ****************************************
// Port checker for the register block
// ****************************************
module pabim_checker (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        phy_req_valid,
   input wire logic        phy_req_write,
   input wire logic [3:0]  phy_req_addr,
   input wire logic        phy_req_ready,
   input wire logic        tx_packet_done,
   input wire logic        tx_inject_header_error,
   input wire logic        tx_inject_payload_error,
   input wire logic        tx_drop_next_packet,
   input wire logic        tx_force_ack,
   input wire logic        tx_suppress_ack,
   input wire logic [7:0]  tx_ack_value
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [11:0] acc_a = pabim_pkg::phy_register_access_off;
   localparam logic [11:0] mnt_a = pabim_pkg::maintenance_control_off;
   logic       wr_acc;
   logic [4:0] hooks;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Combinational terms, so no cycle is lost against the bus
   assign wr_acc = psel && penable && pwrite;
   assign hooks  = {tx_inject_header_error, tx_inject_payload_error, tx_drop_next_packet,
                    tx_force_ack, tx_suppress_ack};
   chk_zero_wait: assert property (psel && penable |-> pready)
      else $error("access cycle without pready");
   chk_no_slverr: assert property (!pslverr)
      else $error("pslverr raised");
   chk_req_held: assert property (phy_req_valid && !phy_req_ready |=> phy_req_valid
      && $stable({phy_req_write, phy_req_addr})) else $error("request changed before taken");
   chk_one_req: assert property (phy_req_valid && phy_req_ready |=> !phy_req_valid)
      else $error("no gap after request");
   chk_read_sent: assert property (wr_acc && paddr == acc_a && pwdata[31] && !phy_req_valid
      |-> ##[1:4] phy_req_valid && !phy_req_write) else $error("read request not issued");
   chk_hook_set: assert property (wr_acc && paddr == mnt_a |-> ##2
      hooks == $past(pwdata[31:27], 2) && tx_ack_value == $past(pwdata[23:16], 2))
      else $error("hook outputs do not follow write");
   chk_hook_clr: assert property (tx_packet_done && !(wr_acc && paddr == mnt_a) |->
      ##2 hooks == 5'h00) else $error("hooks not cleared after packet");
   chk_resv_zero: assert property (psel && !penable && !pwrite && paddr == acc_a |=>
      prdata[29:28] == 2'h0 && prdata[15:12] == 4'h0) else $error("reserved bits not zero");
   // Main scenarios reached
   cover property (phy_req_valid && phy_req_ready && phy_req_write);
   cover property (tx_packet_done && hooks != 5'h00);
   cover property (wr_acc && paddr == mnt_a);
endmodule

bind pabim_top pabim_checker u_chk (.*);

// ===== verification/pabim_phy_model.sv
// ****************************************
// Far-side register model
// ****************************************
module pabim_phy_model (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic [3:0] slow,
   input  wire logic       req_valid,
   input  wire logic       req_write,
   input  wire logic [3:0] req_addr,
   input  wire logic [7:0] req_data,
   output logic            req_ready,
   output logic            reply_valid,
   output logic      [3:0] reply_addr,
   output logic      [7:0] reply_data
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] regs [16];
   logic [3:0] wait_cnt;
   // Ready held back by slow cycles; reads answer one cycle after taken
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {req_ready, reply_valid, reply_addr, reply_data, wait_cnt} <= '0;
         for (int i = 0; i < 16; i++)
            regs[i] <= 8'h00;
      end else begin
         req_ready   <= 1'b0;
         reply_valid <= 1'b0;
         // Idle reply lines toggle, so a stale capture cannot pass
         reply_addr  <= ~reply_addr;
         reply_data  <= ~reply_data;
         if (req_valid && !req_ready && wait_cnt < slow)
            wait_cnt <= wait_cnt + 4'h1;
         else if (req_valid && !req_ready) begin
            req_ready <= 1'b1;
            wait_cnt  <= 4'h0;
         end
         if (req_valid && req_ready && req_write)
            regs[req_addr] <= req_data;
         if (req_valid && req_ready && !req_write) begin
            reply_valid <= 1'b1;
            reply_addr  <= req_addr;
            reply_data  <= regs[req_addr];
         end
      end
   end
endmodule

// ===== verification/phy_access_bus_info_maint_test.sv
// ****************************************
// Bench for the register block
// ****************************************
module phy_access_bus_info_maint_test;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [11:0] acc_a = pabim_pkg::phy_register_access_off;
   localparam logic [11:0] brd_a = pabim_pkg::bus_reset_info_off;
   localparam logic [11:0] mnt_a = pabim_pkg::maintenance_control_off;
   localparam logic [11:0] flg_a = pabim_pkg::link_event_flags_off;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, link_irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic        phy_req_valid, phy_req_write, phy_req_ready, phy_reply_valid;
   logic [3:0]  phy_req_addr, phy_reply_addr, slow;
   logic [7:0]  phy_req_data, phy_reply_data, tx_ack_value;
   logic        bus_reset_seen, self_id_done, self_id_root, contender_pin;
   logic [5:0]  self_id_node_total, self_id_node_id, self_id_rm_id;
   logic        tx_packet_done, ping_start, ping_stop, tx_inject_header_error;
   logic        tx_inject_payload_error, tx_drop_next_packet, tx_force_ack, tx_suppress_ack;
   logic [12:0] hook_bus;
   logic [12:0] seen [$];
   int          bad_count, tests_run;

   pabim_top DUT (.*);
   pabim_phy_model u_phy (.pclk(pclk), .presetn(presetn), .slow(slow),
      .req_valid(phy_req_valid), .req_write(phy_req_write), .req_addr(phy_req_addr),
      .req_data(phy_req_data), .req_ready(phy_req_ready), .reply_valid(phy_reply_valid),
      .reply_addr(phy_reply_addr), .reply_data(phy_reply_data));
   assign hook_bus = {tx_inject_header_error, tx_inject_payload_error, tx_drop_next_packet,
                      tx_force_ack, tx_suppress_ack, tx_ack_value};
   // Log of requests as the far side takes them
   always @(posedge pclk)
      if (phy_req_valid && phy_req_ready)
         seen.push_back({phy_req_write, phy_req_addr, phy_req_data});
   // Clock
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end

   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // One APB transfer; wait on pready is bounded, release after the sampling edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
      int n = 0;
      {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, wd};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      {psel, penable} <= 2'b00;
      @(posedge pclk);
      if (n >= 50) begin
         bad_count++;
         wrap_up();
      end
   endtask

   task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] r;
      apb(1'b0, a, 32'h0, r);
      chk(nm, exp, r);
   endtask

   // Polls a register until the masked bits match, bounded
   task automatic poll(input logic [11:0] a, input logic [31:0] m, input logic [31:0] v);
      logic [31:0] r;
      int n;
      n = 0;
      do begin
         apb(1'b0, a, 32'h0, r);
         n++;
      end while ((r & m) !== v && n < 40);
      if (n >= 40) begin
         bad_count++;
         wrap_up();
      end
   endtask

   task automatic t_reset();
      logic [31:0] r;
      repeat (3) @(posedge pclk);
      rd_chk("bus_reset_info", brd_a, 32'h007f_ffff);
      rd_chk("phy_register_access", acc_a, 32'h0);
      apb(1'b1, 12'h100, 32'hffff_ffff, r);
      rd_chk("unmapped", 12'h100, 32'h0);
      $display("test reset done");
   endtask

   task automatic t_phy();
      logic [31:0] r;
      slow <= 4'h3;
      apb(1'b1, acc_a, 32'h75a7_f000, r);
      poll(acc_a, 32'hc000_0000, 32'h0);
      chk("write request", 32'h15a7, 32'(seen[0]));
      rd_chk("access fields", acc_a, 32'h05a7_0000);
      apb(1'b1, pabim_pkg::link_event_enable_off, 32'h200, r);
      rd_chk("irq enable", pabim_pkg::link_event_enable_off, 32'h200);
      apb(1'b1, acc_a, 32'h85a7_0000, r);
      poll(flg_a, 32'h200, 32'h200);
      rd_chk("reply capture", acc_a, 32'h05a7_05a7);
      chk("irq", 32'h1, 32'(link_irq));
      apb(1'b1, flg_a, 32'h200, r);
      repeat (2) @(posedge pclk);
      chk("irq cleared", 32'h0, 32'(link_irq));
      slow <= 4'h0;
      seen.delete();
      apb(1'b1, acc_a, 32'hc33c_0000, r);
      poll(acc_a, 32'hc000_0000, 32'h0);
      chk("first read", 32'h03, 32'(seen[0][12:8]));
      chk("then write", 32'h133c, 32'(seen[1]));
      poll(flg_a, 32'h200, 32'h200);
      rd_chk("read before write", acc_a, 32'h033c_0300);
      $display("test phy access done");
   endtask

   task automatic t_bus();
      logic [31:0] r;
      contender_pin <= 1'b0;
      {self_id_node_total, self_id_node_id, self_id_rm_id} <= {6'h2a, 6'h05, 6'h11};
      self_id_root <= 1'b1;
      self_id_done <= 1'b1;
      @(posedge pclk);
      self_id_done <= 1'b0;
      repeat (3) @(posedge pclk);
      rd_chk("bus results", brd_a, 32'haa91_ffc5);
      apb(1'b1, pabim_pkg::bus_ctl_off, 32'h1, r);
      rd_chk("bus ctl", pabim_pkg::bus_ctl_off, 32'h1);
      bus_reset_seen <= 1'b1;
      @(posedge pclk);
      bus_reset_seen <= 1'b0;
      repeat (2) @(posedge pclk);
      apb(1'b0, brd_a, 32'h0, r);
      chk("after bus reset", 32'h003f_ffff, r & 32'h803f_ffff);
      $display("test bus info done");
   endtask

   task automatic t_maint();
      logic [31:0] r;
      apb(1'b1, mnt_a, 32'hff5a_ff00, r);
      @(negedge pclk);
      chk("hooks set", 32'h1f5a, 32'(hook_bus));
      @(posedge pclk);
      rd_chk("maint readback", mnt_a, 32'hf85a_0000);
      tx_packet_done <= 1'b1;
      @(posedge pclk);
      tx_packet_done <= 1'b0;
      repeat (2) @(negedge pclk);
      chk("hooks cleared", 32'h005a, 32'(hook_bus));
      @(posedge pclk);
      rd_chk("maint cleared", mnt_a, 32'h005a_0000);
      ping_start <= 1'b1;
      @(posedge pclk);
      ping_start <= 1'b0;
      repeat (19) @(posedge pclk);
      ping_stop <= 1'b1;
      @(posedge pclk);
      ping_stop <= 1'b0;
      rd_chk("ping time", mnt_a, 32'h005a_000a);
      ping_start <= 1'b1;
      @(posedge pclk);
      ping_start <= 1'b0;
      repeat (520) @(posedge pclk);
      rd_chk("ping saturated", mnt_a, 32'h005a_00ff);
      $display("test maintenance done");
   endtask

   // Hang guard
   initial begin
      repeat (50000) @(posedge pclk);
      bad_count++;
      wrap_up();
   end

   // Main sequence
   initial begin
      {bad_count, tests_run} = '0;
      {presetn, psel, penable, pwrite, bus_reset_seen, self_id_done, self_id_root} = '0;
      {tx_packet_done, ping_start, ping_stop} = '0;
      {paddr, pwdata, self_id_node_total, self_id_node_id, self_id_rm_id, slow} = '0;
      contender_pin = 1'b1;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset();
      t_phy();
      t_bus();
      t_maint();
      wrap_up();
   end
endmodule
